// *** cycle_counter.sv ***
// Down-counter that times one bus access for the memory access controller.
module cycle_counter #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] cycles,
  output logic done
);
  logic [W-1:0] count_q;
  logic busy_q;

  // Loads the cycle total less one and counts down; done pulses in the final cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else if (load) begin
      count_q <= cycles - W'(1);
      busy_q <= 1'b1;
    end else if (busy_q && count_q != '0) begin
      count_q <= count_q - W'(1);
    end else begin
      busy_q <= 1'b0;
    end
  end

  assign done = busy_q && (count_q == '0);
endmodule

// *** mem_partner.sv ***
// Behavioural memory and peripheral model that answers the controller's bus accesses.
module mem_partner (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire memctl_pkg::mem_req_t mem_req,
  output logic [15:0] mem_rdata,
  output int n_acc,
  output logic [23:0] last_addr,
  output logic [2:0] last_region,
  output logic last_write,
  output logic [15:0] last_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Presents data derived from the address of the access in progress, ready in its last cycle.
  always_comb begin
    mem_rdata = {~mem_req.addr[7:0], mem_req.addr[7:0]};
  end

  // Records each strobed access.
  // target widths
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      n_acc <= 0;
      last_addr <= 24'h000000;
      last_region <= 3'h7;
      last_write <= 1'b0;
      last_wdata <= 16'h0000;
    end else if (mem_req.strobe) begin
      n_acc <= n_acc + 1;
      last_addr <= mem_req.addr;
      last_region <= mem_req.region;
      last_write <= mem_req.write;
      last_wdata <= mem_req.wdata;
    end
  end
endmodule

// *** memctl.sv ***
// Memory access cycle controller: decode, wait states, splitting and timing registers.
// Overview of operation
// [R1] Flash reads timed by flash timing field.
// [R2] Flash field bits 2:0, RW, reset 3.
// [R3] Codes 0-3 give 2.5-5.5, 4 gives 1.5.
// [R4] Software picks flash code by clock rate.
// [R5] Software avoids too fast flash setting.
// [R6] Internal RAM decoded at 0x0 to 0xfff.
// [R7] RAM read two cycles, write one.
// [R8] Software avoids debug RAM top 64 bytes.
// [R9] Display RAM 8-bit at 0x80000-0x8055f.
// [R10] Display RAM always usable as storage.
// [R11] Display field bits 1:0, RW, reset 3.
// [R12] Display codes 0-3 give 2-5 cycles.
// [R13] Software picks display code by clock.
// [R14] Peripheral areas at 0x4000 and 0x5000.
// [R15] Peripheral area 1 takes one cycle.
// [R16] Peripheral area 2 takes three cycles.
// [R17] Area 2 pwm timer 16-bit, rest 8-bit.
// [R18] Area 1 widths per module group.
// [R19] Wide access split into device accesses.
// [R20] Flash decoded at 0x8000 to 0x17fff.
// [R21] Reserved bits zero; setting applies next.
// [R22] Master stalled until cycles elapse.
module memctl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire memctl_pkg::cpu_req_t cpu_req,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  output memctl_pkg::mem_req_t mem_req,
  input wire logic [15:0] mem_rdata,
  output logic [2:0] flash_read_cycles,
  output logic [1:0] display_ram_cycles
);
  typedef enum logic [1:0] {IDLE = 2'b00, LOAD = 2'b01, WAIT = 2'b10} state_t;
  state_t state_q;
  memctl_pkg::region_t region_d;
  logic wide_dev_d;
  logic [2:0] n_acc_d;
  logic [2:0] acc_idx_q;
  logic [2:0] n_acc_q;
  logic [3:0] cyc_d;
  logic done;
  logic byte_lane;
  logic reg_hit_q;
  logic [7:0] reg_rdata;
  logic [23:0] acc_addr;
  logic [15:0] acc_wdata;

  // Region decode of the request address.
  always_comb begin
    region_d = memctl_pkg::REG_NONE;
    // [R6] RAM window
    if (cpu_req.addr <= memctl_pkg::IRAM_HI) region_d = memctl_pkg::REG_IRAM;
    // [R14] peripheral windows
    else if (cpu_req.addr >= memctl_pkg::PER1_LO && cpu_req.addr <= memctl_pkg::PER1_HI)
      region_d = memctl_pkg::REG_PER1;
    else if (cpu_req.addr >= memctl_pkg::PER2_LO && cpu_req.addr <= memctl_pkg::PER2_HI)
      region_d = memctl_pkg::REG_PER2;
    // [R20] Flash window
    else if (cpu_req.addr >= memctl_pkg::FLASH_LO && cpu_req.addr <= memctl_pkg::FLASH_HI)
      region_d = memctl_pkg::REG_FLASH;
    // [R9] display RAM window
    else if (cpu_req.addr >= memctl_pkg::DRAM_LO && cpu_req.addr <= memctl_pkg::DRAM_HI)
      region_d = memctl_pkg::REG_DRAM;
  end

  // Device width of the target; internal RAM counts as 32-bit.
  always_comb begin
    wide_dev_d = 1'b0;
    unique case (region_d)
      memctl_pkg::REG_FLASH: wide_dev_d = 1'b1;
      // [R18] area 1 widths
      memctl_pkg::REG_PER1: wide_dev_d = (cpu_req.addr >= memctl_pkg::P1_WIDE_LO);
      // [R17] area 2 widths
      memctl_pkg::REG_PER2:
        wide_dev_d = (cpu_req.addr >= memctl_pkg::P2_WIDE_LO) &&
                     (cpu_req.addr <= memctl_pkg::P2_WIDE_HI);
      default: wide_dev_d = 1'b0;
    endcase
  end

  // Number of bus accesses for the request.
  always_comb begin
    n_acc_d = 3'h1;
    // [R19] access splitting
    if (region_d != memctl_pkg::REG_IRAM) begin
      unique case (cpu_req.size)
        memctl_pkg::SZ16: n_acc_d = wide_dev_d ? 3'h1 : 3'h2;
        memctl_pkg::SZ32: n_acc_d = wide_dev_d ? 3'h2 : 3'h4;
        default: n_acc_d = 3'h1;
      endcase
    end
  end

  // Cycles per bus access, using the live timing fields.
  always_comb begin
    cyc_d = memctl_pkg::UNMAP_CYC;
    unique case (region_d)
      // [R7] RAM timing
      memctl_pkg::REG_IRAM:
        cyc_d = cpu_req.write ? memctl_pkg::IRAM_WR_CYC : memctl_pkg::IRAM_RD_CYC;
      // [R15] area 1 timing
      memctl_pkg::REG_PER1: cyc_d = memctl_pkg::PER1_CYC;
      // [R16] area 2 timing
      memctl_pkg::REG_PER2: cyc_d = memctl_pkg::PER2_CYC;
      // [R1] [R3] Flash timing
      memctl_pkg::REG_FLASH: begin
        unique case (flash_read_cycles)
          3'h0: cyc_d = memctl_pkg::FLASH_CYC_C0;
          3'h1: cyc_d = memctl_pkg::FLASH_CYC_C1;
          3'h2: cyc_d = memctl_pkg::FLASH_CYC_C2;
          3'h3: cyc_d = memctl_pkg::FLASH_CYC_C3;
          default: cyc_d = memctl_pkg::FLASH_CYC_C4;
        endcase
      end
      // [R12] [R10] display RAM timing
      memctl_pkg::REG_DRAM: cyc_d = memctl_pkg::DRAM_BASE_CYC + {2'h0, display_ram_cycles};
      default: cyc_d = memctl_pkg::UNMAP_CYC;
    endcase
  end

  // [R22] wait state timer
  cycle_counter #(.W(4)) u_cyc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(state_q == LOAD),
    .cycles(cyc_d),
    .done(done)
  );

  // Address and write data of the current bus access.
  assign byte_lane = !wide_dev_d && (region_d != memctl_pkg::REG_IRAM);
  assign acc_addr = cpu_req.addr + (byte_lane ? {21'h0, acc_idx_q} : {20'h0, acc_idx_q, 1'b0});
  assign acc_wdata = byte_lane ? {8'h00, cpu_req.wdata[8*acc_idx_q[1:0] +: 8]} :
                                 cpu_req.wdata[16*acc_idx_q[0] +: 16];

  // Sequencer over the split bus accesses.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      acc_idx_q <= 3'h0;
      n_acc_q <= 3'h1;
    end else begin
      unique case (state_q)
        IDLE: if (cpu_req.valid && !cpu_ready) begin
          n_acc_q <= n_acc_d;
          acc_idx_q <= 3'h0;
          state_q <= LOAD;
        end
        LOAD: state_q <= WAIT;
        WAIT: if (done) begin
          if (acc_idx_q + 3'h1 == n_acc_q) begin
            state_q <= IDLE;
            acc_idx_q <= 3'h0;
          end else begin
            acc_idx_q <= acc_idx_q + 3'h1;
            state_q <= LOAD;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Bus access outputs, registered.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req <= '0;
    end else begin
      mem_req.strobe <= (state_q == LOAD) && region_d != memctl_pkg::REG_NONE && !reg_hit_q;
      mem_req.write <= cpu_req.write;
      mem_req.region <= region_d;
      mem_req.addr <= acc_addr;
      mem_req.wdata <= acc_wdata;
    end
  end

  // Timing register selection for the current access.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) reg_hit_q <= 1'b0;
    else if (state_q == LOAD || state_q == IDLE)
      reg_hit_q <= (acc_addr == memctl_pkg::FLASH_TIMING_ADDR) ||
                   (acc_addr == memctl_pkg::DRAM_TIMING_ADDR);
  end

  // [R21] reserved bits read zero
  assign reg_rdata = (acc_addr == memctl_pkg::FLASH_TIMING_ADDR) ? {5'h00, flash_read_cycles} :
                     (acc_addr == memctl_pkg::DRAM_TIMING_ADDR) ? {6'h00, display_ram_cycles} :
                     8'h00;

  // [R2] [R11] timing register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_read_cycles <= memctl_pkg::FLASH_CYC_RESET;
      display_ram_cycles <= memctl_pkg::DRAM_CYC_RESET;
    end else if (state_q == WAIT && done && cpu_req.write) begin
      if (acc_addr == memctl_pkg::FLASH_TIMING_ADDR)
        flash_read_cycles <= acc_wdata[2:0];
      if (acc_addr == memctl_pkg::DRAM_TIMING_ADDR)
        display_ram_cycles <= acc_wdata[1:0];
    end
  end

  // Read data assembly and completion toward the master.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_ready <= 1'b0;
      cpu_rdata <= 32'h0000_0000;
    end else begin
      cpu_ready <= 1'b0;
      if (state_q == IDLE && cpu_req.valid && !cpu_ready) cpu_rdata <= 32'h0000_0000;
      if (state_q == WAIT && done) begin
        if (reg_hit_q)
          cpu_rdata[8*acc_idx_q[1:0] +: 8] <= reg_rdata;
        else if (region_d == memctl_pkg::REG_NONE)
          cpu_rdata[8*acc_idx_q[1:0] +: 8] <= 8'h00;
        else if (byte_lane)
          cpu_rdata[8*acc_idx_q[1:0] +: 8] <= mem_rdata[7:0];
        else
          cpu_rdata[16*acc_idx_q[0] +: 16] <= mem_rdata;
        if (acc_idx_q + 3'h1 == n_acc_q) cpu_ready <= 1'b1;
      end
    end
  end

  // Properties checking timing, splitting, reset values and reserved bits.
  property p_reset_fields;
    @(posedge core_clk) $rose(reset_n) |-> flash_read_cycles == 3'h3 && display_ram_cycles == 2'h3;
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("timing fields bad after reset"); // [R2]

  property p_ram_write;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_IRAM && cpu_req.write) |-> ##1 done;
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("RAM write not one cycle"); // [R7]

  property p_ram_read;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_IRAM && !cpu_req.write) |-> ##1 !done ##1 done;
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("RAM read not two cycles"); // [R7]

  property p_per2;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_PER2) |-> ##1 !done [*2] ##1 done;
  endproperty
  a_per2: assert property (p_per2) else $error("area 2 not three cycles"); // [R16]

  property p_per1;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_PER1) |-> ##1 done;
  endproperty
  a_per1: assert property (p_per1) else $error("area 1 not one cycle"); // [R15]

  property p_dram;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_DRAM && display_ram_cycles == 2'h3)
      |-> ##1 !done [*4] ##1 done;
  endproperty
  a_dram: assert property (p_dram) else $error("display RAM not five cycles"); // [R12]

  property p_flash;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD && region_d == memctl_pkg::REG_FLASH && flash_read_cycles == 3'h4)
      |-> ##1 !done ##1 done;
  endproperty
  a_flash: assert property (p_flash) else $error("flash fast setting wrong"); // [R3]

  property p_split;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == IDLE && cpu_req.valid && !cpu_ready && cpu_req.size == memctl_pkg::SZ32 &&
       region_d == memctl_pkg::REG_DRAM) |-> ##1 n_acc_q == 3'h4;
  endproperty
  a_split: assert property (p_split) else $error("32-bit display access not four parts"); // [R19]

  property p_stall;
    @(posedge core_clk) disable iff (!reset_n)
      (state_q == LOAD) |-> ##1 !cpu_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("master released too early"); // [R22]

  property p_reserved;
    @(posedge core_clk) disable iff (!reset_n)
      (cpu_ready && !cpu_req.write && reg_hit_q && cpu_req.size == memctl_pkg::SZ8)
      |-> cpu_rdata[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R21]

  c_flash: cover property (@(posedge core_clk) state_q == LOAD && region_d == memctl_pkg::REG_FLASH);
  c_dram32: cover property (@(posedge core_clk) n_acc_q == 3'h4 && cpu_ready);
  c_regwr: cover property (@(posedge core_clk) state_q == WAIT && done && reg_hit_q && cpu_req.write);
endmodule

// *** memctl_pkg.sv ***
// Package with address map, register layout and cycle tables for the memory access controller.
package memctl_pkg;
  localparam int ADDR_W = 24;
  // Address windows.
  localparam logic [23:0] IRAM_LO = 24'h000000;
  localparam logic [23:0] IRAM_HI = 24'h000FFF;
  localparam logic [23:0] PER1_LO = 24'h004000;
  localparam logic [23:0] PER1_HI = 24'h0043FF;
  localparam logic [23:0] PER2_LO = 24'h005000;
  localparam logic [23:0] PER2_HI = 24'h005FFF;
  localparam logic [23:0] FLASH_LO = 24'h008000;
  localparam logic [23:0] FLASH_HI = 24'h017FFF;
  localparam logic [23:0] DRAM_LO = 24'h080000;
  localparam logic [23:0] DRAM_HI = 24'h08055F;
  // 16-bit register ranges inside peripheral area 1 and area 2.
  localparam logic [23:0] P1_WIDE_LO = 24'h004200;
  localparam logic [23:0] P1_WIDE_HI = 24'h0043FF;
  localparam logic [23:0] P2_WIDE_LO = 24'h005300;
  localparam logic [23:0] P2_WIDE_HI = 24'h00531F;
  // Timing control registers.
  localparam logic [23:0] FLASH_TIMING_ADDR = 24'h005320;
  localparam logic [23:0] DRAM_TIMING_ADDR = 24'h005321;
  localparam logic [2:0] FLASH_CYC_RESET = 3'h3;
  localparam logic [1:0] DRAM_CYC_RESET = 2'h3;
  localparam logic [2:0] FLASH_CYC_MAX = 3'h4;
  // Fixed cycle counts per bus access.
  localparam logic [3:0] IRAM_RD_CYC = 4'h2;
  localparam logic [3:0] IRAM_WR_CYC = 4'h1;
  localparam logic [3:0] PER1_CYC = 4'h1;
  localparam logic [3:0] PER2_CYC = 4'h3;
  localparam logic [3:0] DRAM_BASE_CYC = 4'h2;
  localparam logic [3:0] UNMAP_CYC = 4'h1;
  // Flash half-cycle counts: 2.5,3.5,4.5,5.5,1.5 cycles as whole cycles rounded up.
  localparam logic [3:0] FLASH_CYC_C0 = 4'h3;
  localparam logic [3:0] FLASH_CYC_C1 = 4'h4;
  localparam logic [3:0] FLASH_CYC_C2 = 4'h5;
  localparam logic [3:0] FLASH_CYC_C3 = 4'h6;
  localparam logic [3:0] FLASH_CYC_C4 = 4'h2;
  // Access size codes.
  typedef enum logic [1:0] {SZ8 = 2'b00, SZ16 = 2'b01, SZ32 = 2'b10} size_t;
  // Target regions.
  typedef enum logic [2:0] {
    REG_IRAM = 3'b000, REG_PER1 = 3'b001, REG_PER2 = 3'b010,
    REG_FLASH = 3'b011, REG_DRAM = 3'b100, REG_NONE = 3'b101
  } region_t;
  // Request from the core bus master.
  typedef struct packed {
    logic valid;
    logic write;
    size_t size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } cpu_req_t;
  // One bus access toward a memory or peripheral.
  typedef struct packed {
    logic strobe;
    logic write;
    region_t region;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
endpackage

// *** test_memory_access_cycle_control.sv ***
// Self-checking bench for the memory access cycle controller.
module test_memory_access_cycle_control;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic wr;
    logic [1:0] sz;
    logic [23:0] addr;
    logic [3:0] n;
    logic [3:0] cyc;
    logic [2:0] rgn;
  } row_t;

  logic core_clk;
  logic reset_n;
  memctl_pkg::cpu_req_t cpu_req;
  logic cpu_ready;
  logic [31:0] cpu_rdata;
  memctl_pkg::mem_req_t mem_req;
  logic [15:0] mem_rdata;
  logic [2:0] flash_read_cycles;
  logic [1:0] display_ram_cycles;
  int n_acc;
  logic [23:0] last_addr;
  logic [2:0] last_region;
  logic last_write;
  logic [15:0] last_wdata;
  int errors;
  int tests_run;
  int lat;
  int n0;
  int last_off;
  logic [31:0] rd;
  int fc [8] = '{3, 4, 5, 6, 2, 2, 2, 2};
  row_t rows [12] = '{
    '{0, 2, 24'h000000, 1, 2, 0}, '{1, 1, 24'h000FBE, 1, 1, 0}, '{0, 0, 24'h000FFF, 1, 2, 0},
    '{0, 1, 24'h004200, 1, 1, 1}, '{1, 1, 24'h004100, 2, 1, 1}, '{0, 2, 24'h0043FC, 2, 1, 1},
    '{0, 1, 24'h005300, 1, 3, 2}, '{1, 2, 24'h005000, 4, 3, 2}, '{0, 1, 24'h008000, 1, 6, 3},
    '{0, 2, 24'h017FFC, 2, 6, 3}, '{0, 0, 24'h080000, 1, 5, 4}, '{1, 1, 24'h08055E, 2, 5, 4}
  };

  memctl u_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cpu_req(cpu_req),
    .cpu_ready(cpu_ready),
    .cpu_rdata(cpu_rdata),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata),
    .flash_read_cycles(flash_read_cycles),
    .display_ram_cycles(display_ram_cycles)
  );

  mem_partner u_mem (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata),
    .n_acc(n_acc),
    .last_addr(last_addr),
    .last_region(last_region),
    .last_write(last_write),
    .last_wdata(last_wdata)
  );

  // Free-running core clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask

  // Issues one request, holds it until ready, then releases it.
  task automatic req(input logic wr, input logic [1:0] sz, input logic [23:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    cpu_req <= '{1'b1, wr, memctl_pkg::size_t'(sz), a, wd};
    lat = 0;
    for (k = 0; k < 300; k++) begin
      @(posedge core_clk);
      #1;
      lat++;
      if (cpu_ready === 1'b1) break;
    end
    if (k == 300) begin
      errors++;
      $display("MISMATCH %0t request never answered", $time);
      final_report();
    end else begin
      rd = cpu_rdata;
      @(posedge core_clk);
      cpu_req.valid <= 1'b0;
    end
  endtask

  // Main sequence: reset, the table of accesses, then register and reset cases.
  initial begin
    errors = 0;
    tests_run = 0;
    reset_n = 1'b0;
    cpu_req = '0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    check(32'(flash_read_cycles), 32'h3, "flash field reset");
    check(32'(display_ram_cycles), 32'h3, "display field reset");
    // Table of ordinary accesses; each part costs one set-up cycle plus its bus cycles.
    // No debugger here, so the RAM top is usable.
    foreach (rows[i]) begin
      n0 = n_acc;
      last_off = (rows[i].n > 1) ? (1 << rows[i].sz) - (1 << rows[i].sz) / rows[i].n : 0;
      req(rows[i].wr, rows[i].sz, rows[i].addr, 32'h00A55A3C);
      check(32'(lat), 32'(1 + rows[i].n * (1 + rows[i].cyc)), "latency");
      check(32'(n_acc - n0), 32'(rows[i].n), "access count");
      check(32'(last_region), 32'(rows[i].rgn), "region");
      check(32'(last_write), 32'(rows[i].wr), "direction");
      check(32'(last_addr), 32'(rows[i].addr) + 32'(last_off), "last address");
    end
    // Every flash code, with reserved upper bits set on the write.
    // Codes swept for decode only; the model has no speed limit.
    for (int c = 0; c < 8; c++) begin
      req(1'b1, 2'h0, 24'h005320, {24'h000000, 5'h1F, 3'(c)});
      check(32'(flash_read_cycles), 32'(c), "flash field");
      req(1'b0, 2'h0, 24'h005320, 32'h00000000);
      check(rd, 32'(c), "flash readback");
      req(1'b0, 2'h1, 24'h008000, 32'h00000000);
      check(32'(lat), 32'(2 + fc[c]), "flash latency");
    end
    // Every display RAM code, timed on a split 16-bit write.
    // Codes swept for decode only.
    for (int c = 0; c < 4; c++) begin
      req(1'b1, 2'h0, 24'h005321, {24'h000000, 6'h3F, 2'(c)});
      check(32'(display_ram_cycles), 32'(c), "display field");
      req(1'b0, 2'h0, 24'h005321, 32'h00000000);
      check(rd, 32'(c), "display readback");
      req(1'b1, 2'h1, 24'h080100, 32'h0000BEEF);
      check(32'(lat), 32'(1 + 2 * (3 + c)), "display latency");
      check(32'(last_wdata), 32'h00BE, "display high byte");
    end
    // A neighbouring register leaves both fields alone.
    req(1'b1, 2'h0, 24'h005322, 32'h000000FF);
    check(32'(flash_read_cycles), 32'h7, "flash field kept");
    check(32'(display_ram_cycles), 32'h3, "display field kept");
    // Address just past peripheral area 1 still completes and reads zero.
    req(1'b0, 2'h0, 24'h004400, 32'h00000000);
    check(rd, 32'h0, "unmapped data");
    // Split reads gather their parts low first.
    req(1'b0, 2'h2, 24'h080100, 32'h00000000);
    check(rd, 32'h03020100, "display 32-bit data");
    req(1'b0, 2'h2, 24'h008004, 32'h00000000);
    check(rd, 32'hF906FB04, "flash 32-bit data");
    // Reset in the middle of a flash read restores both defaults.
    @(posedge core_clk);
    cpu_req <= '{1'b1, 1'b0, memctl_pkg::SZ16, 24'h008010, 32'h0};
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b0;
    #1;
    check(32'(cpu_ready), 32'h0, "ready in reset");
    check(cpu_rdata, 32'h0000_0000, "data in reset");
    check(32'(flash_read_cycles), 32'h3, "flash field rearm");
    check(32'(display_ram_cycles), 32'h3, "display field rearm");
    @(posedge core_clk);
    cpu_req <= '0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    req(1'b0, 2'h1, 24'h008010, 32'h00000000);
    check(32'(lat), 32'h8, "flash after reset");
    check(rd, 32'h0000EF10, "flash data after reset");
    final_report();
  end
endmodule
